// ==== common/rio_pkg.sv ====
// Purpose: constants and types for reset, interrupt and option control
// Assumes: 10 MHz core clock, classic wishbone register slave
// Notes: register offsets are byte addresses of 32-bit words
package rio_pkg;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned T_OST_NS      = 18000000;
	localparam int unsigned OST_CYC       =
		(T_OST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int unsigned ADR_W = 8;
	localparam logic [7:0]  OFS_IRQ_FLAG = 8'h00;
	localparam logic [7:0]  OFS_IRQ_MASK = 8'h04;
	localparam logic [7:0]  OFS_RST_STAT = 8'h08;
	localparam logic [7:0]  OFS_SLP_CTRL = 8'h0c;

	localparam int unsigned IRQ_N = 2;
	localparam int unsigned BIT_TMR = 0;
	localparam int unsigned BIT_EXT = 3;
	localparam int unsigned BIT_T = 4;
	localparam int unsigned BIT_P = 3;
	localparam int unsigned BIT_SLEEPING = 0;
	localparam int unsigned BIT_SLP_RESET = 4;
	localparam logic        SLP_CTRL_RST = 1'h1;

	localparam int unsigned VEC_W = 12;
	localparam logic [11:0] VEC_IRQ  = 12'h001;
	localparam logic [11:0] VEC_TRAP = 12'h002;

	localparam int unsigned OPT_W    = 13;
	localparam int unsigned OPT_CLKS = 8;
	localparam int unsigned OPT_WDTB = 7;
	localparam int unsigned OPT_SPEED = 5;
	localparam int unsigned OPT_OSC  = 4;
	localparam int unsigned OPT_POWER = 3;
	localparam int unsigned OPT_PR_HI = 2;
	localparam int unsigned OPT_PR_LO = 0;
	localparam logic [12:0] OPT_RSV_ONES = 13'h1e00;
	localparam logic [2:0]  PR_OPEN = 3'h7;

	typedef enum logic [1:0] {
		SLP_AWAKE  = 2'h0,
		SLP_RESET  = 2'h1,
		SLP_RESUME = 2'h2
	} rio_slp_e;

	typedef enum logic [1:0] {
		OSC_RC   = 2'h0,
		OSC_FAST = 2'h1,
		OSC_SLOW = 2'h3,
		OSC_BAD  = 2'h2
	} rio_osc_e;
endpackage : rio_pkg

// ==== common/rio_opt_if.sv ====
// Purpose: decoded option word between decoder and control top
// Assumes: fields are registered by the decoder
// Notes: valid rises at the first edge after reset release
`timescale 1ns/10ps
interface rio_opt_if;
	logic              valid;
	logic              cyc4;
	logic              wdt_en;
	logic              code_prot;
	rio_pkg::rio_osc_e osc;
	modport src (output valid, cyc4, wdt_en, code_prot, osc);
	modport snk (input valid, cyc4, wdt_en, code_prot, osc);
endinterface : rio_opt_if

// ==== rtl/rio_sync3.sv ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs are asynchronous pin levels
// Notes: output changes only when stages two and three agree
`timescale 1ns/10ps
module rio_sync3 #(
	parameter int unsigned W        = 2,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge core_clk) begin
			if (sys_rst) begin
				q[i] <= RST_VAL[i];
			end else if (s2_q[i] == s3_q[i]) begin
				q[i] <= s3_q[i];
			end
		end
	end
endmodule : rio_sync3

// ==== rtl/rio_optdec.sv ====
// Purpose: capture and decode the one-time option word
// Assumes: option word is static fuse data on the core clock
// Notes: captured once, at the first edge after reset release
`timescale 1ns/10ps
module rio_optdec (
	input  wire logic                     core_clk,
	input  wire logic                     sys_rst,
	input  wire logic [rio_pkg::OPT_W-1:0] opt_word,
	rio_opt_if.src                        opt
);
	logic                      cap_q;
	logic [rio_pkg::OPT_W-1:0] w;

	// reserved bits always one
	assign w = opt_word | rio_pkg::OPT_RSV_ONES;

	always_ff @(posedge core_clk) begin
		cap_q <= sys_rst;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			opt.valid     <= 1'b0;
			opt.cyc4      <= 1'b0;
			opt.wdt_en    <= 1'b0;
			opt.code_prot <= 1'b1;
			opt.osc       <= rio_pkg::OSC_RC;
		end else if (cap_q) begin
			opt.valid     <= 1'b1;
			opt.cyc4      <= w[rio_pkg::OPT_CLKS];
			opt.wdt_en    <= ~w[rio_pkg::OPT_WDTB];
			opt.code_prot <= w[rio_pkg::OPT_PR_HI:rio_pkg::OPT_PR_LO]
				!= rio_pkg::PR_OPEN;
			if (!w[rio_pkg::OPT_OSC]) begin
				opt.osc <= rio_pkg::OSC_RC;
			end else if (w[rio_pkg::OPT_SPEED]) begin
				opt.osc <= rio_pkg::OSC_FAST;
			end else if (!w[rio_pkg::OPT_POWER]) begin
				opt.osc <= rio_pkg::OSC_SLOW;
			end else begin
				opt.osc <= rio_pkg::OSC_BAD;
			end
		end
	end
endmodule : rio_optdec

// ==== rtl/rio_ctrl.sv ====
// Purpose: reset cause, interrupt and option control of the core
// Assumes: sys_rst is the power-on reset; strobes are one-cycle pulses
// Notes: registers on classic wishbone, byte lane 0 only
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
module rio_ctrl #(
	parameter int unsigned HOLD_CYC = rio_pkg::OST_CYC
) (
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [rio_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	input  wire logic                      ext_rst_n_pin,
	input  wire logic                      ext_int_n_pin,
	input  wire logic                      wdt_timeout_i,
	input  wire logic                      tmr_ovf_i,
	input  wire logic                      pin_wake_i,
	input  wire logic                      instr_bound_i,
	input  wire logic                      gie_set_i,
	input  wire logic                      gie_clr_i,
	input  wire logic                      irq_ret_i,
	input  wire logic                      wdog_clr_i,
	input  wire logic                      sleep_cmd_i,
	input  wire logic                      trap_i,
	input  wire logic [rio_pkg::OPT_W-1:0] opt_word_i,
	output logic                           core_rst_o,
	output logic                           flag_t_o,
	output logic                           flag_p_o,
	output logic                           sleep_o,
	output logic                           irq_req_o,
	output logic                           gie_o,
	output logic                           vec_load_o,
	output logic      [rio_pkg::VEC_W-1:0] vec_addr_o,
	output logic                           ret_push_o,
	output logic                           cyc4_o,
	output logic                           wdt_en_o,
	output rio_pkg::rio_osc_e              osc_mode_o,
	output logic                           code_prot_o
);
	localparam int unsigned CNT_W = $clog2(HOLD_CYC + 1);
	localparam logic [CNT_W-1:0] HOLD = HOLD_CYC[CNT_W-1:0];
	localparam int unsigned IRQ_POS [rio_pkg::IRQ_N] =
		'{rio_pkg::BIT_TMR, rio_pkg::BIT_EXT};

	if (HOLD_CYC < 1) begin : g_chk
		$error("rio_ctrl: HOLD_CYC must be at least one");
	end

	rio_opt_if opt ();

	logic [1:0]               pin_s;
	logic                     rstn_prev_q;
	logic                     intn_prev_q;
	logic                     ext_fall;
	logic                     int_fall;
	logic                     wdt_ev;
	logic                     rst_src;
	logic                     rst_ev;
	logic [CNT_W-1:0]         cnt_q;
	rio_pkg::rio_slp_e        slp_q;
	logic [rio_pkg::IRQ_N-1:0] irq_flag_q;
	logic [rio_pkg::IRQ_N-1:0] irq_mask_q;
	logic [rio_pkg::IRQ_N-1:0] irq_ev;
	logic [rio_pkg::IRQ_N-1:0] flag_wd;
	logic                     irq_pend;
	logic                     take;
	logic                     trap;
	logic                     slp_reset_q;
	logic                     bus_req;
	logic                     wr;
	logic [31:0]              rd_d;

	rio_sync3 #(
		.W       (2),
		.RST_VAL (2'h3)
	) u_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.d        ({ext_int_n_pin, ext_rst_n_pin}),
		.q        (pin_s)
	);

	rio_optdec u_opt (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.opt_word (opt_word_i),
		.opt      (opt)
	);

	assign cyc4_o      = opt.cyc4;
	assign wdt_en_o    = opt.wdt_en;
	assign osc_mode_o  = opt.osc;
	assign code_prot_o = opt.code_prot;

	// edge detect on synchronised pins
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rstn_prev_q <= 1'b1;
			intn_prev_q <= 1'b1;
		end else begin
			rstn_prev_q <= pin_s[0];
			intn_prev_q <= pin_s[1];
		end
	end

	assign ext_fall = rstn_prev_q & ~pin_s[0];
	assign int_fall = intn_prev_q & ~pin_s[1];
	assign wdt_ev   = wdt_timeout_i & opt.wdt_en;
	assign rst_src  = ~pin_s[0] | wdt_ev;
	assign rst_ev   = ext_fall | wdt_ev;

	// reset stretch after every source releases
	always_ff @(posedge core_clk) begin
		if (sys_rst || rst_src) begin
			cnt_q <= HOLD;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			core_rst_o <= 1'b1;
		end else begin
			core_rst_o <= rst_src | (cnt_q != '0);
		end
	end

	// sleep state
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			slp_q <= rio_pkg::SLP_AWAKE;
		end else begin
			unique case (slp_q)
				rio_pkg::SLP_AWAKE: begin
					if (sleep_cmd_i && !core_rst_o && !rst_ev) begin
						slp_q <= slp_reset_q ? rio_pkg::SLP_RESET
							: rio_pkg::SLP_RESUME;
					end
				end
				rio_pkg::SLP_RESET: begin
					if (rst_ev) begin
						slp_q <= rio_pkg::SLP_AWAKE;
					end
				end
				rio_pkg::SLP_RESUME: begin
					if (rst_ev || pin_wake_i) begin
						slp_q <= rio_pkg::SLP_AWAKE;
					end
				end
				default: slp_q <= rio_pkg::SLP_AWAKE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sleep_o <= 1'b0;
		end else begin
			sleep_o <= (slp_q != rio_pkg::SLP_AWAKE);
		end
	end

	// time-out and power-down flags
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flag_t_o <= 1'b1;
			flag_p_o <= 1'b1;
		end else if (wdt_ev) begin
			flag_t_o <= 1'b0;
			if (slp_q == rio_pkg::SLP_RESET) begin
				flag_p_o <= 1'b0;
			end
		end else if (ext_fall) begin
			if (slp_q == rio_pkg::SLP_RESET) begin
				flag_t_o <= 1'b1;
				flag_p_o <= 1'b0;
			end
		end else if (!core_rst_o && wdog_clr_i) begin
			flag_t_o <= 1'b1;
			flag_p_o <= 1'b1;
		end else if (!core_rst_o && sleep_cmd_i) begin
			flag_t_o <= 1'b1;
			flag_p_o <= 1'b0;
		end
	end

	// wishbone slave
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// write lands at the edge where the master sees ack
	assign wr      = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always_comb begin
		rd_d = '0;
		unique case (wb_adr_i)
			rio_pkg::OFS_IRQ_FLAG: begin
				for (int i = 0; i < rio_pkg::IRQ_N; i++) begin
					rd_d[IRQ_POS[i]] = irq_flag_q[i];
				end
			end
			rio_pkg::OFS_IRQ_MASK: begin
				for (int i = 0; i < rio_pkg::IRQ_N; i++) begin
					rd_d[IRQ_POS[i]] = irq_mask_q[i];
				end
			end
			rio_pkg::OFS_RST_STAT: begin
				rd_d[rio_pkg::BIT_T]        = flag_t_o;
				rd_d[rio_pkg::BIT_P]        = flag_p_o;
				rd_d[rio_pkg::BIT_SLEEPING] = sleep_o;
			end
			rio_pkg::OFS_SLP_CTRL: begin
				rd_d[rio_pkg::BIT_SLP_RESET] = slp_reset_q;
			end
			default: rd_d = '0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wb_dat_o <= '0;
		end else if (bus_req) begin
			wb_dat_o <= rd_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			slp_reset_q <= rio_pkg::SLP_CTRL_RST;
		end else if (wr && wb_adr_i == rio_pkg::OFS_SLP_CTRL) begin
			slp_reset_q <= wb_dat_i[rio_pkg::BIT_SLP_RESET];
		end
	end

	// interrupt flags and masks, one slice per source
	assign irq_ev = {int_fall, tmr_ovf_i};

	for (genvar i = 0; i < rio_pkg::IRQ_N; i++) begin : g_irq
		assign flag_wd[i] = wb_dat_i[IRQ_POS[i]];

		// event wins over clear and over a reset event
		always_ff @(posedge core_clk) begin
			if (sys_rst) begin
				irq_flag_q[i] <= 1'b0;
			end else if (rst_ev) begin
				irq_flag_q[i] <= irq_ev[i];
			end else if (wr && wb_adr_i == rio_pkg::OFS_IRQ_FLAG) begin
				irq_flag_q[i] <= flag_wd[i] | irq_ev[i];
			end else begin
				irq_flag_q[i] <= irq_flag_q[i] | irq_ev[i];
			end
		end

		always_ff @(posedge core_clk) begin
			if (sys_rst || rst_ev) begin
				irq_mask_q[i] <= 1'b0;
			end else if (wr && wb_adr_i == rio_pkg::OFS_IRQ_MASK) begin
				irq_mask_q[i] <= flag_wd[i];
			end
		end
	end

	assign irq_pend = |(irq_flag_q & irq_mask_q);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_req_o <= 1'b0;
		end else begin
			irq_req_o <= irq_pend;
		end
	end

	// vectoring; trap wins over a hardware interrupt
	assign trap = trap_i & ~core_rst_o;
	assign take = irq_pend & gie_o & instr_bound_i & ~trap & ~core_rst_o
		& (slp_q == rio_pkg::SLP_AWAKE);

	always_ff @(posedge core_clk) begin
		if (sys_rst || rst_ev) begin
			gie_o <= 1'b0;
		end else if (take) begin
			gie_o <= 1'b0;
		end else if (gie_set_i || irq_ret_i) begin
			gie_o <= 1'b1;
		end else if (gie_clr_i) begin
			gie_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			vec_load_o <= 1'b0;
			ret_push_o <= 1'b0;
			vec_addr_o <= '0;
		end else begin
			vec_load_o <= trap | take;
			ret_push_o <= trap | take;
			if (trap) begin
				vec_addr_o <= rio_pkg::VEC_TRAP;
			end else if (take) begin
				vec_addr_o <= rio_pkg::VEC_IRQ;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	rst_entry_a: assert property (
		wdt_ev |=> core_rst_o && cnt_q == HOLD ##1 core_rst_o)
		else $error("watchdog event did not hold core reset");
	por_flags_a: assert property (
		$fell(sys_rst) |-> flag_t_o && flag_p_o)
		else $error("power-on did not set both flags");
	ext_sleep_a: assert property (
		ext_fall && !wdt_ev && slp_q == rio_pkg::SLP_RESET
		|=> flag_t_o && !flag_p_o && slp_q == rio_pkg::SLP_AWAKE ##1 !sleep_o)
		else $error("external wake flags wrong");
	wdt_run_a: assert property (
		wdt_ev && slp_q == rio_pkg::SLP_AWAKE
		|=> !flag_t_o && flag_p_o == $past(flag_p_o))
		else $error("watchdog reset flags wrong");
	wdt_wake_a: assert property (
		wdt_ev && slp_q == rio_pkg::SLP_RESET |=> !flag_t_o && !flag_p_o)
		else $error("watchdog wake flags wrong");
	pin_wake_a: assert property (
		pin_wake_i && !rst_ev && slp_q == rio_pkg::SLP_RESUME
		|=> $stable(flag_t_o) && $stable(flag_p_o) && !core_rst_o)
		else $error("pin wake touched flags");
	sleep_enter_instr_flags_a: assert property (
		sleep_cmd_i && !core_rst_o && !rst_ev && !wdog_clr_i
		|=> flag_t_o && !flag_p_o && slp_q != rio_pkg::SLP_AWAKE)
		else $error("sleep entry flags wrong");
	flag_set_a: assert property (
		tmr_ovf_i |=> irq_flag_q[0])
		else $error("timer flag not set");
	req_and_a: assert property (
		irq_flag_q[1] && irq_mask_q[1] |=> irq_req_o)
		else $error("request not formed from flag and mask");
	irq_vec_a: assert property (
		take |=> vec_load_o && ret_push_o && !gie_o
		&& vec_addr_o == rio_pkg::VEC_IRQ ##1 !vec_load_o)
		else $error("interrupt vector wrong");
	trap_vec_a: assert property (
		trap |=> ret_push_o && vec_addr_o == rio_pkg::VEC_TRAP)
		else $error("trap vector wrong");
	return_from_irq_instr_gie_a: assert property (
		irq_ret_i && !take && !rst_ev |=> gie_o)
		else $error("return did not enable interrupts");
	opt_cap_a: assert property (
		$fell(sys_rst) |=> opt.valid)
		else $error("option word not captured after reset");
endmodule : rio_ctrl

// ==== bench/rio_seq_model.sv ====
// Purpose: sequencer stand-in that takes vectors from the control block
// Assumes: vec_load is a one-cycle pulse, sampled on the rising edge
// Notes: stall holds the instruction boundary low
`timescale 1ns/10ps
module rio_seq_model (
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	input  wire logic                      stall,
	input  wire logic                      vec_load,
	input  wire logic [rio_pkg::VEC_W-1:0] vec_addr,
	input  wire logic                      ret_push,
	output logic                           instr_bound,
	output int                             vec_cnt,
	output int                             push_cnt,
	output logic      [rio_pkg::VEC_W-1:0] last_addr
);
	// busy core refuses interrupts until the boundary comes back
	assign instr_bound = ~stall;
	always @(posedge core_clk) begin
		if (sys_rst) begin
			vec_cnt   <= 0;
			push_cnt  <= 0;
			last_addr <= '0;
		end else if (vec_load) begin
			vec_cnt   <= vec_cnt + 1;
			push_cnt  <= push_cnt + int'(ret_push);
			last_addr <= vec_addr;
		end
	end
endmodule : rio_seq_model

// ==== bench/rio_ctrl_tb_top.sv ====
// Purpose: self-checking bench for reset, interrupt and option control
// Assumes: wishbone ack one cycle after the request
// Notes: stretch count shortened to four cycles
`timescale 1ns/10ps
module rio_ctrl_tb_top;
	logic                     core_clk;
	logic                     sys_rst;
	logic                     cyc;
	logic                     stb;
	logic                     we;
	logic [7:0]               adr;
	logic [3:0]               sel;
	logic [31:0]              dat;
	logic [31:0]              wb_dat_o;
	logic                     wb_ack_o;
	logic                     ext_rst_n;
	logic                     ext_int_n;
	logic [8:0]               p;
	logic [12:0]              opt;
	logic                     core_rst;
	logic                     ft;
	logic                     fp;
	logic                     slp;
	logic                     irq;
	logic                     gie;
	logic                     vload;
	logic [11:0]              vaddr;
	logic                     rpush;
	logic                     cyc4;
	logic                     wdten;
	rio_pkg::rio_osc_e        osc;
	logic                     prot;
	logic                     stall;
	logic                     bound;
	int                       vcnt;
	int                       pcnt;
	logic [11:0]              laddr;
	int                       fail_count;
	int                       checked;

	always #50 core_clk = ~core_clk;

	rio_ctrl #(.HOLD_CYC(4)) dut_u (
		.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.ext_rst_n_pin(ext_rst_n), .ext_int_n_pin(ext_int_n),
		.wdt_timeout_i(p[6]), .tmr_ovf_i(p[7]), .pin_wake_i(p[8]),
		.instr_bound_i(bound), .gie_set_i(p[0]), .gie_clr_i(p[1]),
		.irq_ret_i(p[2]), .wdog_clr_i(p[3]), .sleep_cmd_i(p[4]),
		.trap_i(p[5]),
		.opt_word_i(opt), .core_rst_o(core_rst), .flag_t_o(ft),
		.flag_p_o(fp), .sleep_o(slp), .irq_req_o(irq), .gie_o(gie),
		.vec_load_o(vload), .vec_addr_o(vaddr), .ret_push_o(rpush),
		.cyc4_o(cyc4), .wdt_en_o(wdten), .osc_mode_o(osc),
		.code_prot_o(prot));

	rio_seq_model seq_u (
		.core_clk(core_clk), .sys_rst(sys_rst), .stall(stall),
		.vec_load(vload), .vec_addr(vaddr), .ret_push(rpush),
		.instr_bound(bound), .vec_cnt(vcnt), .push_cnt(pcnt),
		.last_addr(laddr));

	task automatic give_verdict;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] r);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= 4'h1;
		dat <= {24'h0, d};
		do begin
			@(posedge core_clk);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic pulse(input int k);
		@(posedge core_clk);
		p[k] <= 1'b1;
		@(posedge core_clk);
		p <= '0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask : pulse

	task automatic wait_rel;
		int n;
		n = 0;
		while (core_rst !== 1'b0 && n < 60) begin
			@(posedge core_clk);
			n++;
		end
		chk(core_rst, 1'b0);
	endtask : wait_rel

	task automatic do_reset(input logic [12:0] o);
		@(posedge core_clk);
		opt     <= o;
		sys_rst <= 1'b1;
		repeat (8) @(posedge core_clk);
		#1;
		chk({core_rst, ft, fp}, 3'h7);
		@(posedge core_clk);
		sys_rst <= 1'b0;
		wait_rel;
	endtask : do_reset

	// k below zero: external reset pin pulse
	task automatic tp(input int k, input logic [1:0] e);
		if (k < 0) begin
			@(posedge core_clk);
			ext_rst_n <= 1'b0;
			repeat (8) @(posedge core_clk);
			#1;
			chk(core_rst, 1'b1);
			@(posedge core_clk);
			ext_rst_n <= 1'b1;
		end else begin
			pulse(k);
		end
		wait_rel;
		chk({ft, fp}, e);
	endtask : tp

	task automatic test_opt;
		logic [12:0] ow [5] = '{13'h0138, 13'h0036, 13'h0018, 13'h0093,
			13'h0007};
		logic [4:0]  ex [5] = '{5'h1b, 5'h0b, 5'h0d, 5'h07, 5'h08};
		for (int i = 0; i < 5; i++) begin
			do_reset(ow[i]);
			chk({cyc4, wdten}, ex[i][4:3]);
			chk({osc, prot}, ex[i][2:0]);
			if (i == 3) begin
				pulse(6);
				chk(ft, 1'b1);
			end
		end
	endtask : test_opt

	task automatic test_regs;
		logic [31:0] r;
		wb(8'h08, 1'b0, 8'h00, r);
		chk(r, 32'h18);
		wb(8'h0c, 1'b0, 8'h00, r);
		chk(r, 32'h10);
		wb(8'h40, 1'b1, 8'hff, r);
		wb(8'h40, 1'b0, 8'h00, r);
		chk(r, 32'h0);
		wb(8'h00, 1'b0, 8'h00, r);
		chk(r, 32'h0);
	endtask : test_regs

	task automatic test_irq;
		logic [31:0] r;
		pulse(7);
		wb(8'h00, 1'b0, 8'h00, r);
		chk(r, 32'h01);
		chk(irq, 1'b0);
		wb(8'h04, 1'b1, 8'h01, r);
		repeat (2) @(posedge core_clk);
		#1;
		chk(irq, 1'b1);
		@(posedge core_clk);
		stall <= 1'b1;
		pulse(0);
		chk(gie, 1'b1);
		chk(vcnt, 0);
		@(posedge core_clk);
		stall <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		chk({vcnt[3:0], pcnt[3:0], laddr}, 20'h11001);
		chk(gie, 1'b0);
		wb(8'h00, 1'b1, 8'h00, r);
		pulse(2);
		chk(gie, 1'b1);
		pulse(1);
		chk(gie, 1'b0);
		@(posedge core_clk);
		ext_int_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		wb(8'h00, 1'b0, 8'h00, r);
		chk(r, 32'h08);
		wb(8'h04, 1'b1, 8'h09, r);
		wb(8'h04, 1'b0, 8'h00, r);
		chk(r, 32'h09);
		chk(vcnt, 1);
		pulse(0);
		chk(vcnt, 2);
		wb(8'h00, 1'b1, 8'h00, r);
		pulse(5);
		chk({pcnt[3:0], laddr}, 16'h3002);
		@(posedge core_clk);
		ext_int_n <= 1'b1;
	endtask : test_irq

	task automatic test_flags;
		logic [31:0] r;
		tp(3, 2'b11);
		tp(6, 2'b01);
		tp(-1, 2'b01);
		tp(3, 2'b11);
		tp(4, 2'b10);
		chk(slp, 1'b1);
		tp(6, 2'b00);
		tp(4, 2'b10);
		tp(-1, 2'b10);
		wb(8'h0c, 1'b1, 8'h00, r);
		tp(3, 2'b11);
		tp(4, 2'b10);
		tp(8, 2'b10);
		chk(slp, 1'b0);
		tp(4, 2'b10);
		tp(-1, 2'b10);
		wb(8'h0c, 1'b1, 8'h00, r);
		tp(4, 2'b10);
		tp(6, 2'b00);
	endtask : test_flags

	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		give_verdict;
	end

	initial begin
		core_clk   = 1'b0;
		sys_rst    = 1'b1;
		cyc        = 1'b0;
		stb        = 1'b0;
		we         = 1'b0;
		adr        = '0;
		sel        = '0;
		dat        = '0;
		ext_rst_n  = 1'b1;
		ext_int_n  = 1'b1;
		p          = '0;
		opt        = 13'h0007;
		stall      = 1'b0;
		fail_count = 0;
		checked    = 0;
		test_opt;
		test_regs;
		test_irq;
		test_flags;
		give_verdict;
	end
endmodule : rio_ctrl_tb_top
